// File: rtl/wdt_pkg.sv
package wdt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // printed offset is not word aligned, so it is kept as an index
  localparam logic [9:0] CTRL_INDEX = 10'h08f;
  localparam logic [11:0] CTRL_ADDR = {CTRL_INDEX, 2'b00};
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // unused bits 4 and 3 are never stored
  localparam logic [7:0] CTRL_WMASK = 8'he7;
  localparam int CTRL_RESTART_BIT = 6;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int OSC_PER_MC = 12;  // oscillator periods per machine cycle
  localparam int HALF_PER_MC = OSC_PER_MC / 2;  // halved-clock periods
  localparam logic [2:0] HALF_LAST = 3'(HALF_PER_MC - 1);
  localparam logic [13:0] WDT_LAST = 14'h3fff;  // 14-bit rollover point

  // prescaler terminal count per select code (ratio minus one)
  localparam logic [7:0] PRESC_LIMIT [8] = '{
    8'h01, 8'h07, 8'h03, 8'h0f, 8'h1f, 8'h3f, 8'h7f, 8'hff
  };

  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;         // watchdog_enable_bit
    logic restart;    // watchdog_restart_bit
    logic idle_run;   // watchdog_idle_run_bit
    logic [1:0] unused;
    logic [2:0] psel; // prescale_select_msb..lsb
  } ctrl_t;

endpackage

// File: rtl/osc_cycle_div.sv
module osc_cycle_div (
  input wire logic aclk,     // oscillator clock
  input wire logic aresetn,  // sync reset, active low
  output logic mc_tick       // one pulse per machine cycle
);
  import wdt_pkg::*;

  logic half_q;  // oscillator halved, immune to duty cycle
  logic [2:0] cnt_q;  // halved periods within a machine cycle

  // ----------------------------------------------------------------
  // halve the oscillator, then count six halved periods
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q <= 1'b0;
    end else begin
      half_q <= !half_q;  // R10
    end
  end

  // only the rising half advances, so duty cycle never matters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 3'h0;
    end else if (half_q) begin
      cnt_q <= (cnt_q == HALF_LAST) ? 3'h0 : cnt_q + 3'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mc_tick <= 1'b0;
    end else begin
      mc_tick <= half_q && (cnt_q == HALF_LAST);  // R13
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_tick_spacing: assert property (mc_tick |-> ##12 mc_tick) // R13
    else $error("machine tick not every 12 clocks");
  chk_tick_single: assert property (mc_tick |=> !mc_tick) // R10
    else $error("machine tick longer than one clock");

endmodule

// File: rtl/wdt_core.sv
// Overview of operation
// R1 - watchdog comes up disabled after reset
// R2 - reset clears counter and prescaler
// R3 - bit 7 enables running and reset
// R4 - restart bit clears counters, then itself
// R5 - software restarts before time-out expires
// R6 - bit 5 keeps watchdog running in idle
// R7 - select codes map to ratios 2..256
// R8 - time-out after 2^14 x ratio x 12
// R9 - time-out while enabled raises system reset
// R10 - oscillator halved internally before use
// R11 - watchdog keeps its clock in idle
// R12 - control register reads 00h after reset
// R13 - time-out is 14-bit rollover per tick
// R14 - bits 4 and 3 read zero
module wdt_core (
  input wire logic aclk,          // oscillator clock
  input wire logic aresetn,       // sync reset, active low
  input wire logic idle_mode,     // idle indication from power control
  input wire logic [11:0] awaddr, // write address
  input wire logic awvalid,       // write address valid
  output logic awready,           // write address ready
  input wire logic [31:0] wdata,  // write data
  input wire logic [3:0] wstrb,   // write strobes
  input wire logic wvalid,        // write data valid
  output logic wready,            // write data ready
  output logic [1:0] bresp,       // write response
  output logic bvalid,            // write response valid
  input wire logic bready,        // write response ready
  input wire logic [11:0] araddr, // read address
  input wire logic arvalid,       // read address valid
  output logic arready,           // read address ready
  output logic [31:0] rdata,      // read data
  output logic [1:0] rresp,       // read response
  output logic rvalid,            // read data valid
  input wire logic rready,        // read data ready
  output logic wdt_reset          // system reset request, one clock
);
  import wdt_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ctrl_t ctrl_q;  // control register
  logic mc_tick;  // machine-cycle tick
  logic [7:0] pre_q;  // prescaler count
  logic [13:0] cnt_q;  // 14-bit watchdog count
  logic [11:0] awaddr_q;  // held write address
  logic [31:0] wdata_q;  // held write data
  logic [3:0] wstrb_q;  // held strobes
  logic aw_got_q;  // address captured
  logic w_got_q;  // data captured
  logic aw_hs, w_hs, ar_hs, wr_fire;  // handshakes
  logic aw_got_d, w_got_d, bvalid_d, rvalid_d;
  logic wr_hit;  // write lands on the control register
  logic set_restart;  // software asks for a restart
  logic run;  // counting allowed this cycle
  logic [7:0] limit;  // selected prescaler terminal count
  logic pre_wrap;  // prescaler at or past its terminal count
  logic timeout;  // rollover while running

  osc_cycle_div osc_cycle_div_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .mc_tick(mc_tick)
  );

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  always_comb begin
    aw_hs = awvalid && awready;
    w_hs = wvalid && wready;
    ar_hs = arvalid && arready;
    wr_fire = aw_got_q && w_got_q && !bvalid;
    aw_got_d = !wr_fire && (aw_got_q || aw_hs);
    w_got_d = !wr_fire && (w_got_q || w_hs);
    bvalid_d = wr_fire || (bvalid && !bready);
    rvalid_d = ar_hs || (rvalid && !rready);
    wr_hit = wr_fire && (awaddr_q == CTRL_ADDR) && wstrb_q[0];
    set_restart = wr_hit && wdata_q[CTRL_RESTART_BIT];
  end

  // address and data may arrive in either order; hold each one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      // ready drops while a write is pending or unanswered
      awready <= !aw_got_d && !bvalid_d;
      wready <= !w_got_d && !bvalid_d;
      if (aw_hs) begin
        awaddr_q <= awaddr;
      end
      if (w_hs) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
    end
  end

  // write response follows both halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      bvalid <= bvalid_d;
      if (wr_fire) begin
        bresp <= (awaddr_q == CTRL_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // read answers one clock after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else begin
      rvalid <= rvalid_d;
      arready <= !rvalid_d;
      if (ar_hs) begin
        if (araddr == CTRL_ADDR) begin
          rdata <= {24'h00_0000, ctrl_q};  // R14
          rresp <= RESP_OKAY;
        end else begin
          rdata <= 32'h0000_0000;  // unmapped reads zero
          rresp <= RESP_SLVERR;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;  // R1 R12
    end else begin
      if (wr_hit) begin
        ctrl_q <= ctrl_t'(wdata_q[7:0] & CTRL_WMASK);  // R3 R6 R14
      end
      // set wins over the self-clear in the same clock
      if (!set_restart && mc_tick && ctrl_q.restart) begin
        ctrl_q.restart <= 1'b0;  // R4
      end
    end
  end

  // ----------------------------------------------------------------
  // prescaler and 14-bit counter
  // ----------------------------------------------------------------
  always_comb begin
    // the counters sit on the peripheral clock, which idle never stops
    run = ctrl_q.en && (!idle_mode || ctrl_q.idle_run);  // R6 R11
    limit = PRESC_LIMIT[ctrl_q.psel];  // R7
    // >= keeps a lowered ratio from running the prescaler past it
    pre_wrap = pre_q >= limit;
    timeout = run && mc_tick && !ctrl_q.restart && pre_wrap
      && (cnt_q == WDT_LAST);  // R8 R13
  end

  // disabled holds zero, so the interval counts from enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_q <= 8'h00;  // R2
      cnt_q <= 14'h0000;
    end else if (!ctrl_q.en || (mc_tick && ctrl_q.restart)) begin
      pre_q <= 8'h00;  // R4 R5
      cnt_q <= 14'h0000;
    end else if (run && mc_tick) begin
      if (pre_wrap) begin
        pre_q <= 8'h00;
        cnt_q <= cnt_q + 14'h0001;  // R13
      end else begin
        pre_q <= pre_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // system reset request
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= timeout;  // R9
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence restart_due;
    ctrl_q.restart && mc_tick && !set_restart;
  endsequence

  sequence counters_zero;
    (pre_q == 8'h00) && (cnt_q == 14'h0000) && !ctrl_q.restart;
  endsequence

  chk_reset_ctrl: assert property ($rose(aresetn) |-> ctrl_q == 8'h00) // R12
    else $error("control not zero after reset");
  chk_reset_off: assert property ($rose(aresetn) |-> !ctrl_q.en) // R1
    else $error("watchdog enabled after reset");
  chk_reset_count: assert property ($rose(aresetn) // R2
    |-> pre_q == 8'h00 && cnt_q == 14'h0000)
    else $error("counters not cleared by reset");
  chk_off_quiet: assert property (!ctrl_q.en |=> !wdt_reset) // R3
    else $error("reset request while disabled");
  chk_restart_clear: assert property (restart_due |=> counters_zero) // R4
    else $error("restart did not clear counters");
  chk_idle_hold: assert property (ctrl_q.en && idle_mode // R6
    && !ctrl_q.idle_run && !ctrl_q.restart && !wr_hit
    |=> $stable(cnt_q) && $stable(pre_q))
    else $error("watchdog counted in idle");
  chk_presc_wrap: assert property (run && mc_tick && !ctrl_q.restart // R7
    && pre_q == PRESC_LIMIT[ctrl_q.psel] |=> pre_q == 8'h00)
    else $error("prescaler missed its ratio");
  chk_timeout_src: assert property (wdt_reset // R9
    |-> $past(cnt_q) == WDT_LAST && $past(ctrl_q.en))
    else $error("reset request without rollover");
  chk_unused_zero: assert property (rvalid |-> rdata[4:3] == 2'b00 // R14
    && rdata[31:8] == 24'h00_0000)
    else $error("unused bits read nonzero");

endmodule

// File: sim/watchdog_timer_prescaled_tb.sv
module watchdog_timer_prescaled_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import wdt_pkg::*;

  // ------------------------------------------------------------------
  // clock, reset and bus signals
  // ------------------------------------------------------------------
  logic aclk = 1'b0;            // 10 mhz oscillator
  logic aresetn = 1'b0;         // sync reset, active low
  logic idle_mode = 1'b0;       // idle indication
  logic [11:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic wdt_reset;              // system reset request
  int err_count = 0;            // mismatches
  int cmp_count = 0;            // comparisons made
  int pulse_count = 0;          // watchdog resets seen
  int cycle_count = 0;          // hang guard

  always #50 aclk = ~aclk;

  wdt_core wdt_core_i (.aclk(aclk), .aresetn(aresetn),
    .idle_mode(idle_mode), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wdt_reset(wdt_reset));

  // ------------------------------------------------------------------
  // verdict and monitors
  // ------------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // counts reset pulses; the ceiling is far above the planned run length
  always @(posedge aclk) begin
    cycle_count++;
    if (aresetn === 1'b1 && wdt_reset !== 1'b0) pulse_count++;
    if (cycle_count == 80000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ------------------------------------------------------------------
  // bus master tasks
  // ------------------------------------------------------------------
  // address and data go out together; each drops when its own edge hits
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset_value();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(CTRL_ADDR, d, r);
    chk("ctrl after reset", {24'h0, CTRL_RESET}, d);
    chk("watchdog off", 32'h0, pulse_count);
  endtask

  // every select code is stored; unused bits 4 and 3 read zero
  task automatic t_select_codes();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 8; i++) begin
      axi_write(CTRL_ADDR, 32'h38 | i, 4'h1, r);
      chk("write resp", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_read(CTRL_ADDR, d, r);
      chk("select readback", 32'h20 | i, d);
    end
  endtask

  // lane 0 disabled leaves the register alone; unmapped gives slverr
  task automatic t_bus_edges();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(CTRL_ADDR, 32'h05, 4'he, r);
    chk("strobe off wresp", {30'h0, RESP_OKAY}, {30'h0, r});
    axi_read(CTRL_ADDR, d, r);
    chk("strobe off", 32'h27, d);
    axi_write(12'h240, 32'hff, 4'hf, r);
    chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_read(12'h240, d, r);
    chk("unmapped rdata", 32'h0, d);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask

  // enabled and restarted often enough: no reset; restart self-clears
  task automatic t_restart_keeps_alive();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(CTRL_ADDR, 32'h80, 4'h1, r);
    for (int k = 0; k < 12; k++) begin
      repeat (2000) @(posedge aclk);
      axi_write(CTRL_ADDR, 32'hc0, 4'h1, r);
      repeat (30) @(posedge aclk);
      axi_read(CTRL_ADDR, d, r);
      chk("restart self clear", 32'h80, d);
    end
    chk("no timeout", 32'h0, pulse_count);
  endtask

  // idle without idle-run holds the count; the register is untouched
  task automatic t_idle_hold();
    logic [31:0] d;
    logic [1:0] r;
    idle_mode <= 1'b1;
    repeat (5000) @(posedge aclk);
    axi_read(CTRL_ADDR, d, r);
    chk("idle ctrl", 32'h80, d);
    // the restart path keeps its clock while the processor idles
    axi_write(CTRL_ADDR, 32'hc0, 4'h1, r);
    repeat (30) @(posedge aclk);
    axi_read(CTRL_ADDR, d, r);
    chk("idle restart clear", 32'h80, d);
    idle_mode <= 1'b0;
    chk("idle no timeout", 32'h0, pulse_count);
  endtask

  // a second reset puts the register back to zero
  task automatic t_second_reset();
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(CTRL_ADDR, d, r);
    chk("ctrl after 2nd reset", 32'h0, d);
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_value();
    t_select_codes();
    t_bus_edges();
    t_restart_keeps_alive();
    t_idle_hold();
    t_second_reset();
    give_verdict();
  end
endmodule
